// ===== tb_tmr_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

module tb_tmr_ctrl;
  import tmr_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pri, sec, tout, o;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr;
  logic [15:0] cnt, c0, tab, pc;
  int nt, nm;
  logic [15:0] cap_tab [6] = '{16'h1A40, 16'h0840, 16'h3210, 16'h3030, 16'h4610, 16'h0410};
  int error_cnt = 0;
  int total_checks = 0;

  tmr_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .primary_input_pin(pri), .secondary_input_pin(sec), .timer_output(tout), .count_value(cnt));

  // 20 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task close_out;
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task ck(input bit ok, input string m);
    total_checks++;
    if (!ok)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  // Readback keeps implemented bits only
  function automatic logic [31:0] f_rb(input logic [7:0] a, input logic [31:0] x);
    return (a == OFS_TMC) ? (x & 32'h0000000F) : (x & 32'h00000007);
  endfunction

  // Readies sampled mid-cycle, so no race with the edge
  // Answer taken one cycle late, so a waiting response is exercised
  task wr(input logic [7:0] a, input logic [31:0] x, input logic [3:0] s);
    logic ra, rw, p, h, b;
    logic [1:0] rs;
    awaddr <= a;
    wdata <= x;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    h = 1'b0;
    b = 1'b0;
    rs = 2'h3;
    while (!b)
    begin
      @(negedge aclk);
      ra = awready;
      rw = wready;
      p = bvalid;
      b = p && h;
      rs = bresp;
      @(posedge aclk);
      if (ra)
        awvalid <= 1'b0;
      if (rw)
        wvalid <= 1'b0;
      if (p && !h)
        bready <= 1'b1;
      h = h | p;
    end
    bready <= 1'b0;
    ck(b && rs === RESP_OKAY, "write");
  endtask

  task rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] r);
    logic ra, p, h, b;
    araddr <= a;
    arvalid <= 1'b1;
    h = 1'b0;
    b = 1'b0;
    while (!b)
    begin
      @(negedge aclk);
      ra = arready;
      p = rvalid;
      b = p && h;
      x = rdata;
      r = rresp;
      @(posedge aclk);
      if (ra)
        arvalid <= 1'b0;
      if (p && !h)
        rready <= 1'b1;
      h = h | p;
    end
    rready <= 1'b0;
    ck(b, "read");
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, rr);
    ck(d === e && rr === RESP_OKAY, "readback");
  endtask

  // Pin pulse held four aclk cycles
  task pulse(input bit s);
    pri <= ~s;
    sec <= s;
    repeat (4) @(posedge aclk);
    pri <= 1'b0;
    sec <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  // Watchdog, sized for one full counter wrap
  initial
  begin
    repeat (90000) @(posedge aclk);
    error_cnt++;
    close_out;
  end

  initial
  begin
    aresetn <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, pri, sec} <= '0;
    {awaddr, araddr, wdata, wstrb} <= '0;
    v = $urandom(32'hB1BC);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(OFS_TMC, 32'h0);
    rc(OFS_CRC, 32'h0);
    rd(8'h18, d, rr);
    ck(rr === RESP_SLVERR && d === 32'h0, "unmapped");
    // Random contents, stopped timer only
    for (int i = 0; i < 8; i++)
    begin
      v = $urandom;
      wr(OFS_CRC, v, 4'hF);
      rc(OFS_CRC, f_rb(OFS_CRC, v));
      wr(OFS_CRC, ~v, 4'hE);
      rc(OFS_CRC, f_rb(OFS_CRC, v));
      v = v & 32'hFFFFFFF3;
      wr(OFS_TMC, v, 4'h1);
      rc(OFS_TMC, f_rb(OFS_TMC, v));
    end
    // Free run through one wrap
    wr(OFS_TMC, 32'h0, 4'h1);
    wr(OFS_CRC, 32'h0, 4'h1);
    wr(OFS_PSC, 32'h0, 4'h1);
    wr(OFS_CR2, 32'h8000, 4'h3);
    wr(OFS_TMC, 32'h4, 4'h1);
    @(negedge aclk);
    c0 = cnt;
    repeat (4) @(negedge aclk);
    ck(cnt === c0 + 16'h4, "free run");
    for (int n = 0; n < 70000 && cnt !== 16'hFFFF; n++)
      @(negedge aclk);
    @(negedge aclk);
    ck(cnt === 16'h0, "wrap");
    @(posedge aclk);
    rc(OFS_TMC, 32'h5);
    wr(OFS_TMC, 32'h4, 4'h1);
    rc(OFS_TMC, 32'h4);
    wr(OFS_TMC, 32'h1, 4'h1);
    @(negedge aclk);
    ck(cnt === 16'h0, "stop");
    @(posedge aclk);
    rc(OFS_TMC, 32'h0);
    // Clear on first match
    wr(OFS_CR1, 32'h10, 4'h3);
    wr(OFS_TMC, 32'hC, 4'h1);
    c0 = 16'h0;
    nt = 0;
    nm = 0;
    @(negedge aclk);
    o = tout;
    pc = cnt;
    repeat (60)
    begin
      @(negedge aclk);
      if (cnt > c0)
        c0 = cnt;
      if (tout !== o)
        nt++;
      if (cnt === 16'h0 && pc === 16'h10)
        nm++;
      o = tout;
      pc = cnt;
    end
    ck(c0 === 16'h10, "match clear");
    ck(nt == nm && nm > 1, "match toggle");
    @(posedge aclk);
    wr(OFS_TMC, 32'h0, 4'h1);
    wr(OFS_CR1, 32'h8000, 4'h3);
    // Pin edge clear and toggle, edge from the prescaler field
    for (int c = 0; c < 3; c++)
    begin
      wr(OFS_PSC, (c == 2) ? 32'h20 : 32'h10, 4'h1);
      wr(OFS_TMC, (c == 0) ? 32'h8 : 32'hA, 4'h1);
      repeat (30) @(posedge aclk);
      @(negedge aclk);
      o = tout;
      @(posedge aclk);
      pulse(1'b0);
      @(negedge aclk);
      ck(tout === (o ^ (c == 1)), "toggle");
      ck((cnt < 16'hA) === (c < 2), "edge clear");
      @(posedge aclk);
      wr(OFS_TMC, 32'h0, 4'h1);
    end
    // Capture table: control, pin, target, expectation, prescaler
    for (int i = 0; i < 6; i++)
    begin
      tab = cap_tab[i];
      wr(OFS_CRC, {28'h0, tab[15:12]}, 4'h1);
      wr(OFS_PSC, {24'h0, tab[7:0]}, 4'h1);
      wr(OFS_CR1, 32'h8000, 4'h3);
      wr(OFS_CR2, 32'h8000, 4'h3);
      wr(OFS_TMC, 32'h4, 4'h1);
      repeat (20 + $urandom % 20) @(posedge aclk);
      @(negedge aclk);
      c0 = cnt;
      @(posedge aclk);
      pulse(tab[11]);
      wr(OFS_TMC, 32'h0, 4'h1);
      rd(tab[10] ? OFS_CR2 : OFS_CR1, d, rr);
      ck(tab[9] ? (d >= c0 && d <= c0 + 16'hC) : d === 32'h8000, "capture");
    end
    close_out;
  end
endmodule

bind tmr_ctrl tmr_ctrl_checker chk_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .count_value(count_value));

`default_nettype wire

// ===== tmr_ctrl.sv
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Reset clears the mode register to zero.
// - Counter runs once enable field is nonzero, stops when returned to zero.
// - Enable field zero disables timer, stops its clock, clears the counter.
// - Enable 01 free-run, 10 clear on pin edge, 11 clear on first match.
// - Output toggles on either match; condition bit 1 adds primary pin edge.
// - Overflow flag sets whenever counter wraps from maximum to zero.
// - Overflow flag clears on software zero write or enable field set zero.
// - Software writing one to overflow flag sets it.
// - Primary pin valid edge comes from prescaler bits 5 and 4.
// - Reset clears the capture/compare control register to zero.
// - Second register compares at 0, captures at 1.
// - First register captures on secondary edge at 0, primary reverse edge at 1.
// - Both-edge primary selection gives no reverse-phase capture edge.
// - Partial writes change only the addressed bits of both control registers.
// - First register compares at 0, captures at 1.
// - A register in compare mode ignores capture triggers.
module tmr_ctrl
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [tmr_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [tmr_pkg::DATA_W-1:0] wdata,
  input wire logic [tmr_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [tmr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [tmr_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Timer pins
  input wire logic primary_input_pin,
  input wire logic secondary_input_pin,
  output logic timer_output,
  // Counter value for neighbouring logic
  output logic [tmr_pkg::CNT_W-1:0] count_value
);
  import tmr_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [7:0] tmc;
    logic [7:0] crc;
    logic [7:0] psc;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cr1;
    logic [CNT_W-1:0] cr2;
    logic [DIV_W-1:0] div;
    logic tout;
  } tmr_state_t;

  tmr_state_t s_q;
  tmr_state_t s_d;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic [1:0] pin_vec;
  logic [3:0] sel_vec;
  logic [1:0] valid_vec;
  logic [1:0] reverse_vec;
  logic [1:0] mode;
  logic run;
  logic [DIV_W-1:0] cks_mask;
  logic tick;
  logic match1;
  logic match2;
  logic cap1_trig;
  logic cap2_trig;

  // Byte-lane merge of a write into an old register image
  function automatic logic [DATA_W-1:0] wmerge(input logic [DATA_W-1:0] old_val,
                                               input logic [DATA_W-1:0] data,
                                               input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < STRB_W; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction

  // Handshakes; one write and one read in flight at most
  assign awready = ~s_q.aw_got & ~s_q.bvalid;
  assign wready = ~s_q.w_got & ~s_q.bvalid;
  assign arready = ~s_q.rvalid;
  assign aw_hs = awvalid & awready;
  assign w_hs = wvalid & wready;
  assign ar_hs = arvalid & arready;

  // Address and data may arrive in either order
  assign wr_addr = s_q.aw_got ? s_q.aw_addr : awaddr;
  assign wr_data = s_q.w_got ? s_q.w_data : wdata;
  assign wr_strb = s_q.w_got ? s_q.w_strb : wstrb;
  assign do_wr = (s_q.aw_got | aw_hs) & (s_q.w_got | w_hs);

  // Bus outputs straight from state
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign timer_output = s_q.tout;
  assign count_value = s_q.cnt;

  // Pin edge detectors, primary in slot 0
  assign pin_vec = {secondary_input_pin, primary_input_pin};
  assign sel_vec = {s_q.psc[PSC_SEC_LO +: 2], s_q.psc[PSC_PRI_LO +: 2]};

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_edge
      tmr_edge_det u_edge
      (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(pin_vec[g]),
        .edge_sel(sel_vec[g*2 +: 2]),
        .valid_edge(valid_vec[g]),
        .reverse_edge(reverse_vec[g])
      );
    end
  endgenerate

  // Mode decode and count-clock enable
  // Power-of-two ratios only, so a mask of the low divider bits finds the tick
  assign mode = s_q.tmc[TMC_EN_HI:TMC_EN_LO];
  assign run = (mode != OPM_STOP);
  assign cks_mask = DIV_W'((1 << s_q.psc[PSC_CKS_LO +: 2]) - 1);
  assign tick = run & ((s_q.div & cks_mask) == cks_mask);

  // Compare matches only for registers in compare mode
  assign match1 = tick & ~s_q.crc[CRC_MODE1] & (s_q.cnt == s_q.cr1);
  assign match2 = tick & ~s_q.crc[CRC_MODE2] & (s_q.cnt == s_q.cr2);

  // Capture triggers; compare-mode registers never capture
  assign cap1_trig = run & s_q.crc[CRC_MODE1] &
                     (s_q.crc[CRC_TRIG] ? reverse_vec[0] : valid_vec[1]);
  assign cap2_trig = run & s_q.crc[CRC_MODE2] & valid_vec[0];

  // Next-state logic for bus, registers and counter
  always_comb
  begin
    logic [DATA_W-1:0] merged;
    logic [7:0] new_tmc;
    logic ovf_hw;
    merged = '0;
    new_tmc = s_q.tmc;
    ovf_hw = 1'b0;
    s_d = s_q;

    // Accept address and data independently
    if (aw_hs)
    begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (w_hs)
    begin
      s_d.w_got = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (s_q.bvalid && bready)
      s_d.bvalid = 1'b0;

    // Register writes, byte lanes only; device trusts software on
    if (do_wr)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (wr_addr)
        OFS_TMC:
        begin
          merged = wmerge(DATA_W'(s_q.tmc), wr_data, wr_strb);
          new_tmc = merged[7:0] & TMC_MASK;
          // Stopping the timer drops the flag, whatever bit 0 carried
          if (new_tmc[TMC_EN_HI:TMC_EN_LO] == OPM_STOP && run)
            new_tmc[TMC_OVF] = 1'b0;
          s_d.tmc = new_tmc;
        end
        OFS_CRC:
        begin
          merged = wmerge(DATA_W'(s_q.crc), wr_data, wr_strb);
          s_d.crc = merged[7:0] & CRC_MASK;
        end
        OFS_PSC:
        begin
          merged = wmerge(DATA_W'(s_q.psc), wr_data, wr_strb);
          s_d.psc = merged[7:0] & PSC_MASK;
        end
        OFS_CR1:
        begin
          merged = wmerge(DATA_W'(s_q.cr1), wr_data, wr_strb);
          s_d.cr1 = merged[CNT_W-1:0];
        end
        OFS_CR2:
        begin
          merged = wmerge(DATA_W'(s_q.cr2), wr_data, wr_strb);
          s_d.cr2 = merged[CNT_W-1:0];
        end
        OFS_CNT:
          s_d.bresp = RESP_OKAY;
        default:
          s_d.bresp = RESP_SLVERR;
      endcase
    end

    // Count-clock divider, held at zero while stopped
    // Clearing it on stop makes the first tick after a start land at a fixed cycle
    if (run)
      s_d.div = DIV_W'(s_q.div + 1'b1);
    else
      s_d.div = DIV_ZERO;

    // Counter
    if (!run)
      s_d.cnt = CNT_ZERO;
    else
    begin
      if (tick)
      begin
        if (s_q.cnt == CNT_MAX)
        begin
          s_d.cnt = CNT_ZERO;
          ovf_hw = 1'b1;
        end
        else if (mode == OPM_CLR_MATCH && match1)
          s_d.cnt = CNT_ZERO;
        else
          s_d.cnt = CNT_W'(s_q.cnt + 1'b1);
      end
      if (mode == OPM_CLR_EDGE && valid_vec[0])
        s_d.cnt = CNT_ZERO;
    end

    // Hardware overflow wins over a same-cycle software clear
    if (ovf_hw)
      s_d.tmc[TMC_OVF] = 1'b1;

    // Captures win over a same-cycle software write
    // Captured value is the count before this edge's update
    if (cap1_trig)
      s_d.cr1 = s_q.cnt;
    if (cap2_trig)
      s_d.cr2 = s_q.cnt;

    // Output toggle
    // Matches only count on a tick, so a slow count clock toggles once per value
    if (run && (match1 || match2 || (s_q.tmc[TMC_COND] && valid_vec[0])))
      s_d.tout = ~s_q.tout;

    // Read channel
    // Data registered at the handshake, so it stays put while rvalid waits
    if (s_q.rvalid && rready)
      s_d.rvalid = 1'b0;
    if (ar_hs)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      unique case (araddr)
        OFS_TMC: s_d.rdata = DATA_W'(s_q.tmc);
        OFS_CRC: s_d.rdata = DATA_W'(s_q.crc);
        OFS_PSC: s_d.rdata = DATA_W'(s_q.psc);
        OFS_CNT: s_d.rdata = DATA_W'(s_q.cnt);
        OFS_CR1: s_d.rdata = DATA_W'(s_q.cr1);
        OFS_CR2: s_d.rdata = DATA_W'(s_q.cr2);
        default:
        begin
          s_d.rdata = '0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // State register; all control state has a defined reset value
  // Pins need no reset, they are taken as synchronous to aclk
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q.aw_got <= 1'b0;
      s_q.aw_addr <= '0;
      s_q.w_got <= 1'b0;
      s_q.w_data <= '0;
      s_q.w_strb <= '0;
      s_q.bvalid <= 1'b0;
      s_q.bresp <= RESP_OKAY;
      s_q.rvalid <= 1'b0;
      s_q.rdata <= '0;
      s_q.rresp <= RESP_OKAY;
      s_q.tmc <= TMC_RST;
      s_q.crc <= CRC_RST;
      s_q.psc <= PSC_RST;
      s_q.cnt <= CNT_ZERO;
      s_q.cr1 <= CR_RST;
      s_q.cr2 <= CR_RST;
      s_q.div <= DIV_ZERO;
      s_q.tout <= 1'b0;
    end
    else
      s_q <= s_d;
  end

endmodule

`default_nettype wire

// ===== tmr_ctrl_checker.sv
`timescale 1ns/1ns
`default_nettype none

module tmr_ctrl_checker
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic [tmr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [tmr_pkg::DATA_W-1:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // Timer count
  input wire logic [tmr_pkg::CNT_W-1:0] count_value
);
  import tmr_pkg::*;
  logic [ADDR_W-1:0] ar_q;

  // Address of the read in flight, steady while rvalid stands
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ar_q <= 8'h00;
    else if (arvalid && arready)
      ar_q <= araddr;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Handshakes taken at one edge
  sequence s_wtake;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rtake;
    arvalid && arready;
  endsequence

  property p_wr_ans;
    s_wtake |=> bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  property p_rd_ans;
    s_rtake |=> rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  // Reset leaves the counter cleared
  property p_rst_zero;
    $rose(aresetn) |-> count_value == CNT_ZERO;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("count not cleared");
  // Counter only steps by one or clears
  property p_cnt_step;
    $changed(count_value) |-> count_value == $past(count_value) + 16'h1 || count_value == CNT_ZERO;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("count jumped");
  property p_tmc_upper;
    rvalid && ar_q == OFS_TMC |-> rdata[31:4] == 28'h0;
  endproperty
  a_tmc_upper: assert property (p_tmc_upper) else $error("mode upper bits set");
  property p_crc_upper;
    rvalid && ar_q == OFS_CRC |-> rdata[31:3] == 29'h0;
  endproperty
  a_crc_upper: assert property (p_crc_upper) else $error("control upper bits set");
endmodule

`default_nettype wire

// ===== tmr_edge_det.sv
`timescale 1ns/1ns
`default_nettype none

module tmr_edge_det
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and edge selection
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  // Detected edges, one-cycle pulses
  output logic valid_edge,
  output logic reverse_edge
);
  import tmr_pkg::*;

  typedef struct packed {
    logic prev;
  } tmr_edge_state_t;

  tmr_edge_state_t s_q;
  tmr_edge_state_t s_d;
  logic rise;
  logic fall;

  // Raw transitions against last sample
  assign rise = pin & ~s_q.prev;
  assign fall = ~pin & s_q.prev;

  // Edge decode; both-edge mode has no opposite phase
  always_comb
  begin
    s_d = s_q;
    s_d.prev = pin;
    valid_edge = 1'b0;
    reverse_edge = 1'b0;
    unique case (edge_sel)
      EDG_FALL:
      begin
        valid_edge = fall;
        reverse_edge = rise;
      end
      EDG_RISE:
      begin
        valid_edge = rise;
        reverse_edge = fall;
      end
      EDG_BOTH:
      begin
        valid_edge = rise | fall;
        reverse_edge = 1'b0;
      end
      EDG_NONE:
      begin
        valid_edge = 1'b0;
        reverse_edge = 1'b0;
      end
    endcase
  end

  // Sample register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q.prev <= 1'b0;
    else
      s_q <= s_d;
  end

endmodule

`default_nettype wire

// ===== tmr_pkg.sv
package tmr_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int CNT_W = 16;
  localparam int DIV_W = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_TMC = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CRC = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PSC = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CNT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CR1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CR2 = 8'h14;

  // Reset values
  localparam logic [7:0] TMC_RST = 8'h00;
  localparam logic [7:0] CRC_RST = 8'h00;
  localparam logic [7:0] PSC_RST = 8'h00;
  localparam logic [CNT_W-1:0] CR_RST = 16'h0000;

  // Implemented-bit masks, unused upper bits stay zero
  localparam logic [7:0] TMC_MASK = 8'h0F;
  localparam logic [7:0] CRC_MASK = 8'h07;
  localparam logic [7:0] PSC_MASK = 8'hF3;

  // timer_mode_control fields
  localparam int TMC_OVF = 0;
  localparam int TMC_COND = 1;
  localparam int TMC_EN_LO = 2;
  localparam int TMC_EN_HI = 3;

  // capture_compare_control fields
  localparam int CRC_MODE1 = 0;
  localparam int CRC_TRIG = 1;
  localparam int CRC_MODE2 = 2;

  // prescaler_mode_reg fields (two bits each)
  localparam int PSC_CKS_LO = 0;
  localparam int PSC_PRI_LO = 4;
  localparam int PSC_SEC_LO = 6;

  // Operation enable field values
  localparam logic [1:0] OPM_STOP = 2'h0;
  localparam logic [1:0] OPM_FREE = 2'h1;
  localparam logic [1:0] OPM_CLR_EDGE = 2'h2;
  localparam logic [1:0] OPM_CLR_MATCH = 2'h3;

  // Edge select codes
  localparam logic [1:0] EDG_FALL = 2'h0;
  localparam logic [1:0] EDG_RISE = 2'h1;
  localparam logic [1:0] EDG_NONE = 2'h2;
  localparam logic [1:0] EDG_BOTH = 2'h3;

  // Counter limits
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [DIV_W-1:0] DIV_ZERO = 3'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
